// [rtl/tcpwm_pkg.sv]
package tcpwm_pkg;

    localparam int CNT_W = 16;
    localparam int DB_W = 8;
    localparam int NSRC = 4;
    localparam int SYNC_STAGES = 3;

    // Counting modes
    localparam logic [1:0] MODE_FREE = 2'h0;
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_GATED = 2'h2;

    // Compare selections
    localparam logic [2:0] CMP_LT = 3'h0;
    localparam logic [2:0] CMP_LTE = 3'h1;
    localparam logic [2:0] CMP_EQ = 3'h2;
    localparam logic [2:0] CMP_GTE = 3'h3;
    localparam logic [2:0] CMP_GT = 3'h4;

    // Interrupt source select bit positions
    localparam int IRQ_TC_BIT = 0;
    localparam int IRQ_CMP_BIT = 1;
    localparam int IRQ_CAP_BIT = 2;

    localparam logic [15:0] PERIOD_RST = 16'hFFFF;
    localparam logic [15:0] COMPARE_RST = 16'h7FFF;

    typedef enum logic [1:0] {
        TCPWM_IDLE = 2'b00,
        TCPWM_RUN = 2'b01,
        TCPWM_DONE = 2'b11
    } tcpwm_state_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] cmp_sel;
        logic [2:0] irq_sel;
        logic [1:0] clk_sel;
        logic tc_is_cmp_n;
        logic [7:0] deadband;
    } tcpwm_cfg_t;

    typedef struct packed {
        logic enable;
        logic reset;
        logic capture;
        logic kill;
    } tcpwm_pins_t;

endpackage : tcpwm_pkg

// [rtl/tcpwm_sync.sv]
`timescale 1ns/1ns
// Three-stage synchroniser; a change counts once stages two and three agree
module tcpwm_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] out_next;

    always_comb
    begin
        out_next = out_reg;
        for (int i = 0; i < W; i++)
        begin
            if (s2_reg[i] == s3_reg[i])
            begin
                out_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end
        else
        begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_o = out_reg;

endmodule : tcpwm_sync

// [rtl/tcpwm_top.sv]
`timescale 1ns/1ns
module tcpwm_top #(
    parameter int NCLK = tcpwm_pkg::NSRC
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic [NCLK-1:0] clk_src_i,
    input wire tcpwm_pkg::tcpwm_cfg_t cfg_i,
    input wire logic [15:0] period_i,
    input wire logic [15:0] compare_i,
    input wire tcpwm_pkg::tcpwm_pins_t pins_i,
    output logic cmp_o,
    output logic tc_o,
    output logic irq_o,
    output logic running_o,
    output logic [15:0] count_o,
    output logic [15:0] capture_o
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation
    tcpwm_pkg::tcpwm_pins_t pins_s;
    logic [NCLK-1:0] src_s;

    tcpwm_sync #(.W(4)) u_sync_pins (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .async_i(pins_i),
        .sync_o(pins_s)
    );

    tcpwm_sync #(.W(NCLK)) u_sync_clk (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .async_i(clk_src_i),
        .sync_o(src_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Counting tick and edge detection
    logic src_prev_reg;
    logic rst_prev_reg;
    logic cap_prev_reg;
    logic start_prev_reg;
    logic src_sel;
    logic tick;
    logic rst_evt;
    logic cap_evt;
    logic start_evt;

    assign src_sel = src_s[cfg_i.clk_sel];
    // Source clocks are sampled and each level must be seen on two samples in a row, so each must be below a quarter of the system rate
    assign tick = src_sel & ~src_prev_reg;
    assign rst_evt = pins_s.reset & ~rst_prev_reg;
    assign cap_evt = pins_s.capture & ~cap_prev_reg;
    assign start_evt = start_i & ~start_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Counter state
    tcpwm_pkg::tcpwm_state_t state_reg;
    tcpwm_pkg::tcpwm_state_t state_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [15:0] cap_reg;
    logic [15:0] cap_next;
    logic tc_evt;
    logic count_ok;

    assign count_ok = (cfg_i.mode != tcpwm_pkg::MODE_GATED) || pins_s.enable;
    assign tc_evt = (state_reg == tcpwm_pkg::TCPWM_RUN) && tick && count_ok
        && (cnt_reg == 16'h0000);

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        cap_next = cap_reg;
        if (cap_evt)
        begin
            cap_next = cnt_reg;
        end
        case (state_reg)
            tcpwm_pkg::TCPWM_IDLE:
            begin
                if (start_evt)
                begin
                    cnt_next = period_i;
                    state_next = tcpwm_pkg::TCPWM_RUN;
                end
            end
            tcpwm_pkg::TCPWM_RUN:
            begin
                if (rst_evt)
                begin
                    cnt_next = period_i;
                end
                else if (tc_evt)
                begin
                    cnt_next = period_i;
                    if (cfg_i.mode == tcpwm_pkg::MODE_ONESHOT)
                    begin
                        state_next = tcpwm_pkg::TCPWM_DONE;
                    end
                end
                else if (tick && count_ok)
                begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end
            tcpwm_pkg::TCPWM_DONE:
            begin
                if (start_evt)
                begin
                    cnt_next = period_i;
                    state_next = tcpwm_pkg::TCPWM_RUN;
                end
                else if (rst_evt)
                begin
                    cnt_next = period_i;
                end
            end
            default:
            begin
                state_next = tcpwm_pkg::TCPWM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= tcpwm_pkg::TCPWM_IDLE;
            cnt_reg <= tcpwm_pkg::PERIOD_RST;
            cap_reg <= 16'h0000;
            src_prev_reg <= 1'b0;
            rst_prev_reg <= 1'b0;
            cap_prev_reg <= 1'b0;
            start_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cap_reg <= cap_next;
            src_prev_reg <= src_sel;
            rst_prev_reg <= pins_s.reset;
            cap_prev_reg <= pins_s.capture;
            start_prev_reg <= start_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare, deadband and outputs
    logic cmp_raw;
    logic cmp_d_reg;
    logic [7:0] db_reg;
    logic [7:0] db_next;
    logic cmp_o_next;
    logic tc_o_next;
    logic irq_next;
    logic cmp_evt;
    logic cmp_out_reg;
    logic tc_out_reg;
    logic irq_reg;
    logic run_reg;
    logic [15:0] cnt_out_reg;

    always_comb
    begin
        case (cfg_i.cmp_sel)
            tcpwm_pkg::CMP_LT: cmp_raw = cnt_reg < compare_i;
            tcpwm_pkg::CMP_LTE: cmp_raw = cnt_reg <= compare_i;
            tcpwm_pkg::CMP_EQ: cmp_raw = cnt_reg == compare_i;
            tcpwm_pkg::CMP_GTE: cmp_raw = cnt_reg >= compare_i;
            tcpwm_pkg::CMP_GT: cmp_raw = cnt_reg > compare_i;
            default: cmp_raw = 1'b0;
        endcase
    end

    assign cmp_evt = cmp_raw & ~cmp_d_reg;

    always_comb
    begin
        db_next = db_reg;
        if (cmp_raw != cmp_d_reg)
        begin
            db_next = cfg_i.deadband;
        end
        else if (db_reg != 8'h00)
        begin
            db_next = db_reg - 8'h01;
        end
        cmp_o_next = cmp_raw && (db_next == 8'h00);
        tc_o_next = cfg_i.tc_is_cmp_n ? (!cmp_raw && (db_next == 8'h00)) : tc_evt;
        if (pins_s.kill)
        begin
            cmp_o_next = 1'b0;
            if (cfg_i.tc_is_cmp_n)
            begin
                tc_o_next = 1'b0;
            end
        end
        irq_next = (cfg_i.irq_sel[tcpwm_pkg::IRQ_TC_BIT] && tc_evt)
            || (cfg_i.irq_sel[tcpwm_pkg::IRQ_CMP_BIT] && cmp_evt)
            || (cfg_i.irq_sel[tcpwm_pkg::IRQ_CAP_BIT] && cap_evt);
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cmp_d_reg <= 1'b0;
            db_reg <= 8'h00;
            cmp_out_reg <= 1'b0;
            tc_out_reg <= 1'b0;
            irq_reg <= 1'b0;
            run_reg <= 1'b0;
            cnt_out_reg <= 16'h0000;
        end
        else
        begin
            cmp_d_reg <= cmp_raw;
            db_reg <= db_next;
            cmp_out_reg <= cmp_o_next;
            tc_out_reg <= tc_o_next;
            irq_reg <= irq_next;
            // running flag from next state, so it stays in step with the state
            run_reg <= (state_next == tcpwm_pkg::TCPWM_RUN);
            cnt_out_reg <= cnt_reg;
        end
    end

    assign running_o = run_reg;
    assign cmp_o = cmp_out_reg;
    assign tc_o = tc_out_reg;
    assign irq_o = irq_reg;
    assign count_o = cnt_out_reg;
    assign capture_o = cap_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_kill: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        pins_s.kill |=> !cmp_o)
    else $error("compare output active during kill");

    a_down: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (state_reg == tcpwm_pkg::TCPWM_RUN && tick && count_ok && !rst_evt
            && cnt_reg != 16'h0000) |=> cnt_reg == $past(cnt_reg) - 16'h0001)
    else $error("counter did not decrement");

    a_gate: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (cfg_i.mode == tcpwm_pkg::MODE_GATED && !pins_s.enable && !rst_evt
            && !start_evt) |=> $stable(cnt_reg))
    else $error("gated counter moved while disabled");

    a_reload: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        tc_evt && !rst_evt |=> cnt_reg == $past(period_i))
    else $error("no reload at terminal count");

    a_oneshot: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (tc_evt && !rst_evt && cfg_i.mode == tcpwm_pkg::MODE_ONESHOT)
            |=> state_reg == tcpwm_pkg::TCPWM_DONE)
    else $error("one shot kept running");

    a_capture: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        cap_evt |=> ##1 capture_o == $past(cnt_reg, 2))
    else $error("capture value wrong");

    a_tc: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (tc_evt && !cfg_i.tc_is_cmp_n) |=> tc_o ##1 !tc_o)
    else $error("terminal pulse not one cycle");

    a_irq: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (cap_evt && cfg_i.irq_sel[tcpwm_pkg::IRQ_CAP_BIT]) |=> irq_o)
    else $error("capture interrupt missing");

    a_dead: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !(cmp_o && tc_o && cfg_i.tc_is_cmp_n))
    else $error("complementary outputs overlap");

    // Mirror resets to zero while the count resets to PERIOD_RST, so skip the first edge
    a_live: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        $past(reset_n_i) |-> count_o == $past(cnt_reg))
    else $error("live count mirror stale");

endmodule : tcpwm_top

// [verification/tb.sv]
`timescale 1ns/1ns
module tb;
    typedef struct {logic [2:0] cs; int n; logic e;} tcpwm_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic go = 1'b0;
    logic [1:0] src = 2'h0;
    logic [3:0] srcs;
    tcpwm_pkg::tcpwm_cfg_t cfg = '0;
    tcpwm_pkg::tcpwm_pins_t pins = '0;
    logic [15:0] period = 16'h0005;
    logic [15:0] compare = 16'h0003;
    logic cmp_o, tc_o, irq_o, running_o;
    logic [15:0] count_o, capture_o;
    int n_fail = 0;
    int check_count = 0;
    int tc_n = 0;
    int irq_n = 0;
    int ov_n = 0;
    tcpwm_row_t rows[10] = '{'{3'h0, 3, 1'b1}, '{3'h0, 2, 1'b0}, '{3'h1, 2, 1'b1},
        '{3'h1, 1, 1'b0}, '{3'h2, 2, 1'b1}, '{3'h2, 1, 1'b0}, '{3'h3, 2, 1'b1},
        '{3'h3, 3, 1'b0}, '{3'h4, 1, 1'b1}, '{3'h4, 2, 1'b0}};

    always #5 clk = ~clk;

    tcpwm_fabric tcpwm_fabric_inst (.clk_sys_i(clk), .go_i(go), .src_i(src),
        .clk_src_o(srcs));

    tcpwm_top tcpwm_top_inst (.clk_sys_i(clk), .reset_n_i(rst_n), .start_i(start),
        .clk_src_i(srcs), .cfg_i(cfg), .period_i(period), .compare_i(compare),
        .pins_i(pins), .cmp_o(cmp_o), .tc_o(tc_o), .irq_o(irq_o),
        .running_o(running_o), .count_o(count_o), .capture_o(capture_o));

    // Pulses last one cycle, so they are counted as they pass
    always @(posedge clk)
    begin
        if (tc_o === 1'b1)
            tc_n++;
        if (irq_o === 1'b1)
            irq_n++;
        if (cmp_o === 1'b1 && tc_o === 1'b1 && cfg.tc_is_cmp_n)
            ov_n++;
    end

    ////////////////////////////////////////////////////////////////////////
    task test_done;
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Ticks are spaced well past the three-stage synchroniser
    task tick(input int n);
        repeat (n)
        begin
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            repeat (12) @(posedge clk);
        end
    endtask : tick

    task pulse(input int b);
        pins[b] <= 1'b1;
        repeat (6) @(posedge clk);
        pins[b] <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : pulse

    task run(input logic [1:0] m, input logic [2:0] cs, input logic [15:0] p);
        rst_n <= 1'b0;
        cfg.mode <= m;
        cfg.cmp_sel <= cs;
        period <= p;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : run

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        chk(count_o, 16'h0000);
        chk({15'h0, running_o}, 16'h0000);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i])
        begin
            run(tcpwm_pkg::MODE_FREE, rows[i].cs, 16'h0005);
            tick(rows[i].n);
            chk(count_o, 16'(5 - rows[i].n));
            chk({15'h0, cmp_o}, {15'h0, rows[i].e});
        end
        // Unselected source must not count
        src <= 2'h2;
        tick(1);
        chk(count_o, 16'h0003);
        cfg.clk_sel <= 2'h2;
        tick(1);
        chk(count_o, 16'h0002);
        // Terminal count, reload and interrupt
        cfg.irq_sel <= 3'h1;
        run(tcpwm_pkg::MODE_FREE, 3'h0, 16'h0002);
        tc_n = 0;
        irq_n = 0;
        tick(3);
        chk(count_o, 16'h0002);
        chk(16'(tc_n), 16'h0001);
        chk(16'(irq_n), 16'h0001);
        run(tcpwm_pkg::MODE_ONESHOT, 3'h0, 16'h0001);
        chk({15'h0, running_o}, 16'h0001);
        tick(2);
        chk({15'h0, running_o}, 16'h0000);
        // Gated counting, capture and reset pin
        cfg.irq_sel <= 3'h4;
        run(tcpwm_pkg::MODE_GATED, 3'h0, 16'h0005);
        tick(1);
        chk(count_o, 16'h0005);
        pins.enable <= 1'b1;
        repeat (6) @(posedge clk);
        tick(1);
        chk(count_o, 16'h0004);
        irq_n = 0;
        pulse(1);
        chk(capture_o, 16'h0004);
        chk(16'(irq_n), 16'h0001);
        tick(2);
        pulse(2);
        chk(count_o, 16'h0005);
        pins.enable <= 1'b0;
        // Kill idles the compare output
        run(tcpwm_pkg::MODE_FREE, tcpwm_pkg::CMP_GTE, 16'h0005);
        chk({15'h0, cmp_o}, 16'h0001);
        pins.kill <= 1'b1;
        repeat (8) @(posedge clk);
        chk({15'h0, cmp_o}, 16'h0000);
        pins.kill <= 1'b0;
        // Complementary pair with deadband
        cfg.tc_is_cmp_n <= 1'b1;
        cfg.deadband <= 8'h04;
        run(tcpwm_pkg::MODE_FREE, tcpwm_pkg::CMP_GTE, 16'h0005);
        repeat (12) @(posedge clk);
        chk({14'h0, cmp_o, tc_o}, 16'h0002);
        tick(3);
        repeat (12) @(posedge clk);
        chk({14'h0, cmp_o, tc_o}, 16'h0001);
        chk(16'(ov_n), 16'h0000);
        test_done();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done();
    end
endmodule : tb

// [verification/tcpwm_fabric.sv]
`timescale 1ns/1ns
// Far side: each request gives one high pulse on the chosen source line
module tcpwm_fabric (
    input wire logic clk_sys_i,
    input wire logic go_i,
    input wire logic [1:0] src_i,
    output logic [3:0] clk_src_o
);
    logic [2:0] hold_reg = 3'h0;

    always @(posedge clk_sys_i)
    begin
        if (go_i)
            hold_reg <= 3'h4;
        else if (hold_reg != 3'h0)
            hold_reg <= hold_reg - 3'h1;
    end

    assign clk_src_o = (hold_reg != 3'h0) ? (4'h1 << src_i) : 4'h0;
endmodule : tcpwm_fabric
